// File: rflmac_top.sv
// medium access control of a hopping packet radio: retries, back-off,
// streaming pause, sync session and receive address filtering
// assumes one 100 MHz clock, synchronous inputs, radio handles framing
`include "rflmac_regs.svh"
`default_nettype none

module rflmac_fifo #(
   parameter int W = 8,
   parameter int D = 4
) (
   input  wire logic         i_clk,
   input  wire logic         i_rst,
   input  wire logic         i_valid,
   input  wire logic [W-1:0] i_data,
   output logic              o_ready,
   output logic              o_valid,
   output logic [W-1:0]      o_data,
   input  wire logic         i_ready
);
   // depth must be a power of two so the pointers wrap by themselves
   localparam int AW = $clog2(D);
   logic [W-1:0]  mem_q [D];
   logic [AW-1:0] wp_q;
   logic [AW-1:0] rp_q;
   logic [AW:0]   cnt_q;
   wire           push = i_valid && o_ready;
   wire           pop  = o_valid && i_ready;

   assign o_ready = cnt_q != (AW+1)'(D);
   assign o_valid = cnt_q != '0;
   assign o_data  = mem_q[rp_q];

   always_ff @(posedge i_clk)
      if (push)
         mem_q[wp_q] <= i_data;

   always_ff @(posedge i_clk or posedge i_rst)
      if (i_rst)
      begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
      end
      else
      begin
         wp_q  <= wp_q + AW'(push);
         rp_q  <= rp_q + AW'(pop);
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
endmodule // rflmac_fifo

module rflmac_top #(
   parameter int unsigned SLOT_CYC  = `RFL_SLOT_CYC,
   parameter int unsigned UNIT_CYC  = `RFL_UNIT_CYC,
   // arbitrary neutral value
   parameter logic [15:0] FACTORY_ID = 16'h5A5A
) (
   input  wire logic                     i_clk,
   input  wire logic                     i_rst,
   input  wire logic [3:0]               i_addr,
   input  wire logic [15:0]              i_wdata,
   input  wire logic                     i_wr,
   input  wire logic                     i_rd,
   output logic [15:0]                   o_rdata,
   input  wire logic                     i_tx_valid,
   input  wire logic [7:0]               i_tx_data,
   output logic                          o_tx_ready,
   output rflmac_pkg::rflmac_air_tx_t    o_air_tx,
   output logic                          o_air_tx_valid,
   input  wire logic                     i_air_tx_ready,
   input  wire logic                     i_air_ack,
   input  wire rflmac_pkg::rflmac_air_rx_t i_air_rx,
   input  wire logic                     i_air_rx_valid,
   output logic                          o_ack_send,
   output logic                          o_rx_valid,
   output logic [7:0]                    o_rx_data,
   output logic                          o_sync_live
);
   logic [15:0] net_id_q, mask_q, dest_q;
   logic [7:0]  slot_num_q, retry_lim_q, sync_time_q;
   logic [15:0] stream_lim_q;
   logic [15:0] rdata_q;
   logic [15:0] lfsr_q;
   logic [31:0] cyc_q, cyc_d;
   logic [31:0] ucyc_q;
   logic [7:0]  sess_q;
   logic [8:0]  slots_q, slots_d;
   logic [7:0]  att_q, att_d;
   logic [15:0] sent_q, sent_d;
   logic        done, pop;
   logic        rx_v_q;
   logic [7:0]  rx_d_q;
   logic        ack_q;
   rflmac_pkg::rflmac_state_t  st_q, st_d;
   rflmac_pkg::rflmac_air_tx_t pkt_q;
   logic        f_valid;
   logic [7:0]  f_data;

   rflmac_fifo #(
      .W (8),
      .D (`RFL_FIFO_DEPTH)
   ) u_fifo (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_valid (i_tx_valid),
      .i_data  (i_tx_data),
      .o_ready (o_tx_ready),
      .o_valid (f_valid),
      .o_data  (f_data),
      .i_ready (pop)
   );

   // register decode
   wire wr_id     = i_wr && i_addr == `RFL_OFS_NET_ID;
   wire wr_mask   = i_wr && i_addr == `RFL_OFS_ADDR_MASK;
   wire wr_dest   = i_wr && i_addr == `RFL_OFS_DEST_ADDR;
   wire wr_slots  = i_wr && i_addr == `RFL_OFS_DELAY_SLOTS;
   wire wr_retry  = i_wr && i_addr == `RFL_OFS_RETRY_LIM;
   wire wr_sync   = i_wr && i_addr == `RFL_OFS_SYNC_TIME;
   wire wr_stream = i_wr && i_addr == `RFL_OFS_STREAM_LIM;
   wire retry_on  = retry_lim_q != 8'h00;
   wire sync_live = sync_time_q != 8'h00 && sess_q != 8'h00;
   wire [15:0] status = {att_q, 4'h0,
                         st_q == rflmac_pkg::ST_PAUSE,
                         st_q == rflmac_pkg::ST_BACKOFF,
                         st_q == rflmac_pkg::ST_WAIT_ACK,
                         sync_live};
   wire [15:0] rd_mux =
      i_addr == `RFL_OFS_NET_ID      ? net_id_q :
      i_addr == `RFL_OFS_ADDR_MASK   ? mask_q :
      i_addr == `RFL_OFS_DEST_ADDR   ? dest_q :
      i_addr == `RFL_OFS_DELAY_SLOTS ? {8'h00, slot_num_q} :
      i_addr == `RFL_OFS_RETRY_LIM   ? {8'h00, retry_lim_q} :
      i_addr == `RFL_OFS_SYNC_TIME   ? {8'h00, sync_time_q} :
      i_addr == `RFL_OFS_STREAM_LIM  ? stream_lim_q :
      i_addr == `RFL_OFS_STATUS      ? status : 16'h0000;

   always_ff @(posedge i_clk or posedge i_rst)
      if (i_rst)
      begin
         net_id_q <= `RFL_RST_NET_ID;
         mask_q   <= `RFL_RST_ADDR_MASK;
         dest_q   <= `RFL_RST_DEST_ADDR;
         slot_num_q   <= `RFL_RST_DELAY_SLOTS;
         retry_lim_q  <= `RFL_RST_RETRY_LIM;
         sync_time_q  <= `RFL_RST_SYNC_TIME;
         stream_lim_q <= `RFL_RST_STREAM_LIM;
         rdata_q  <= 16'h0000;
      end
      else
      begin
         if (wr_id) net_id_q <= i_wdata;
         if (wr_mask) mask_q <= i_wdata;
         if (wr_dest) dest_q <= i_wdata;
         if (wr_slots) slot_num_q <= i_wdata[7:0];
         if (wr_retry) retry_lim_q <= i_wdata[7:0];
         if (wr_sync) sync_time_q <= i_wdata[7:0];
         if (wr_stream) stream_lim_q <= i_wdata;
         if (i_rd) rdata_q <= rd_mux;
      end
   assign o_rdata = rdata_q;

   // network identity and receive filter
   wire [15:0] eff_id = net_id_q == `RFL_NET_ID_FACTORY ?
                        FACTORY_ID : net_id_q;
   wire        rx_net_ok = i_air_rx_valid &&
                           i_air_rx.net_id == eff_id;
   wire [15:0] rx_masked = i_air_rx.dest & mask_q;
   wire        rx_addr_ok = rx_masked == dest_q ||
                            rx_masked == mask_q;
   wire        rx_accept = rx_net_ok && rx_addr_ok;

   always_ff @(posedge i_clk or posedge i_rst)
      if (i_rst)
      begin
         rx_v_q <= 1'b0;
         rx_d_q <= 8'h00;
         ack_q  <= 1'b0;
      end
      else
      begin
         rx_v_q <= rx_accept;
         ack_q  <= rx_accept && retry_on;
         if (rx_accept)
            rx_d_q <= i_air_rx.data;
      end
   assign o_rx_valid = rx_v_q;
   assign o_rx_data  = rx_d_q;
   assign o_ack_send = ack_q;

   // free-running lfsr, taps 16,14,13,11
   always_ff @(posedge i_clk or posedge i_rst)
      if (i_rst)
         lfsr_q <= `RFL_RST_LFSR;
      else
         lfsr_q <= {lfsr_q[14:0],
                    lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};

   // modulo on a byte of lfsr: small bias traded for one divider each
   wire [8:0] bo_slots = slot_num_q == 8'h00 ? 9'h000 :
                         {1'b0, lfsr_q[7:0] % slot_num_q};
   wire [8:0] pause_slots = 9'h001 + ({1'b0, lfsr_q[7:0]} %
                            ({1'b0, slot_num_q} + 9'h001));

   // session timer in 100 ms units since last packet either way
   wire unit_tick = ucyc_q == UNIT_CYC - 1;
   wire tx_hs     = o_air_tx_valid && i_air_tx_ready;
   always_ff @(posedge i_clk or posedge i_rst)
      if (i_rst)
      begin
         ucyc_q <= 32'h0000_0000;
         sess_q <= 8'h00;
      end
      else
      begin
         ucyc_q <= unit_tick ? 32'h0000_0000 : ucyc_q + 32'h0000_0001;
         if (tx_hs || rx_net_ok)
            sess_q <= sync_time_q;
         else if (unit_tick && sess_q != 8'h00)
            sess_q <= sess_q - 8'h01;
      end
   assign o_sync_live = sync_live;

   // transmit sequencer
   wire slot_end = cyc_q == SLOT_CYC - 1;
   wire load = st_d == rflmac_pkg::ST_SEND &&
               st_q != rflmac_pkg::ST_SEND;

   always_comb
   begin
      st_d    = st_q;
      slots_d = slots_q;
      cyc_d   = cyc_q;
      att_d   = att_q;
      sent_d  = sent_q;
      done    = 1'b0;
      case (st_q)
         rflmac_pkg::ST_IDLE:
         begin
            cyc_d = 32'h0000_0000;
            if (!f_valid)
               sent_d = 16'h0000;
            else
            begin
               att_d = 8'h01;
               st_d  = rflmac_pkg::ST_SEND;
            end
         end
         rflmac_pkg::ST_SEND:
            if (i_air_tx_ready)
            begin
               cyc_d = 32'h0000_0000;
               if (retry_on)
                  st_d = rflmac_pkg::ST_WAIT_ACK;
               else
                  done = 1'b1;
            end
         rflmac_pkg::ST_WAIT_ACK:
            if (i_air_ack)
               done = 1'b1;
            else if (!slot_end)
               cyc_d = cyc_q + 32'h0000_0001;
            else if (att_q >= retry_lim_q)
               done = 1'b1;
            else
            begin
               att_d   = att_q + 8'h01;
               slots_d = bo_slots;
               cyc_d   = 32'h0000_0000;
               st_d    = rflmac_pkg::ST_BACKOFF;
            end
         rflmac_pkg::ST_BACKOFF,
         rflmac_pkg::ST_PAUSE:
            if (slots_q == 9'h000)
               st_d = st_q == rflmac_pkg::ST_BACKOFF ?
                      rflmac_pkg::ST_SEND : rflmac_pkg::ST_IDLE;
            else if (slot_end)
            begin
               cyc_d   = 32'h0000_0000;
               slots_d = slots_q - 9'h001;
            end
            else
               cyc_d = cyc_q + 32'h0000_0001;
         default:
            st_d = rflmac_pkg::ST_IDLE;
      endcase
      if (done)
      begin
         cyc_d  = 32'h0000_0000;
         sent_d = sent_q + 16'h0001;
         st_d   = rflmac_pkg::ST_IDLE;
         if (stream_lim_q != 16'h0000 && sent_d == stream_lim_q)
         begin
            sent_d  = 16'h0000;
            slots_d = pause_slots;
            st_d    = rflmac_pkg::ST_PAUSE;
         end
      end
   end
   assign pop = done;

   always_ff @(posedge i_clk or posedge i_rst)
      if (i_rst)
      begin
         st_q    <= rflmac_pkg::ST_IDLE;
         slots_q <= 9'h000;
         cyc_q   <= 32'h0000_0000;
         att_q   <= 8'h00;
         sent_q  <= 16'h0000;
      end
      else
      begin
         st_q    <= st_d;
         slots_q <= slots_d;
         cyc_q   <= cyc_d;
         att_q   <= att_d;
         sent_q  <= sent_d;
      end

   // packet is rebuilt for every attempt so the sync flag stays current
   always_ff @(posedge i_clk or posedge i_rst)
      if (i_rst)
         pkt_q <= '0;
      else if (load)
      begin
         pkt_q.net_id    <= eff_id;
         pkt_q.dest      <= dest_q;
         pkt_q.with_sync <= !sync_live;
         pkt_q.data      <= f_data;
      end
   assign o_air_tx       = pkt_q;
   assign o_air_tx_valid = st_q == rflmac_pkg::ST_SEND;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   a_rx_drop_bad: assert property (i_air_rx_valid && !rx_addr_ok
      |=> !o_rx_valid) else $error("unmatched address delivered");
   a_rx_pass_data: assert property (rx_accept |=> o_rx_valid &&
      o_rx_data == $past(i_air_rx.data))
      else $error("matched packet not delivered");
   a_net_mismatch: assert property (i_air_rx_valid &&
      i_air_rx.net_id != eff_id |=> !o_rx_valid && !o_ack_send)
      else $error("foreign network packet accepted");
   a_tx_dest_addr: assert property (o_air_tx_valid && !$rose(o_air_tx_valid)
      && !$past(wr_dest) |-> o_air_tx.dest == dest_q)
      else $error("packet dest differs from setting");
   a_sync_zero_on: assert property ($rose(o_air_tx_valid) &&
      $past(sync_time_q) == 8'h00 |-> o_air_tx.with_sync)
      else $error("sync info missing with zero session");
   a_sync_omitted: assert property ($rose(o_air_tx_valid) &&
      $past(sync_live) |-> !o_air_tx.with_sync)
      else $error("sync info sent in live session");
   a_no_retry_ack: assert property (tx_hs && !retry_on
      |=> st_q != rflmac_pkg::ST_WAIT_ACK)
      else $error("ack awaited with retries off");
   a_backoff_range: assert property (st_q == rflmac_pkg::ST_BACKOFF &&
      $past(st_q) == rflmac_pkg::ST_WAIT_ACK |-> retry_on &&
      (slots_q < {1'b0, slot_num_q} || slots_q == 9'h000))
      else $error("back-off slots out of range");
   a_pause_range: assert property (st_q == rflmac_pkg::ST_PAUSE &&
      $past(st_q) != rflmac_pkg::ST_PAUSE |-> slots_q >= 9'h001 &&
      slots_q <= {1'b0, $past(slot_num_q)} + 9'h001 &&
      $past(stream_lim_q) != 16'h0000)
      else $error("pause slots out of range");
   a_attempt_cap: assert property (st_q == rflmac_pkg::ST_WAIT_ACK
      |-> att_q >= 8'h01 && att_q <= retry_lim_q)
      else $error("attempt count beyond limit");
   a_ack_return: assert property (rx_accept && retry_on |=> o_ack_send)
      else $error("no ack returned");

   c_ack_taken: cover property (st_q == rflmac_pkg::ST_WAIT_ACK
      && i_air_ack);
   c_backoff: cover property (st_q == rflmac_pkg::ST_BACKOFF);
   c_pause: cover property (st_q == rflmac_pkg::ST_PAUSE);
   c_rx_deliver: cover property (o_rx_valid);
endmodule // rflmac_top
`default_nettype wire

// File: rflmac_regs.svh
// register offsets, reset values, status fields and timing of the mac
// assumes a 100 MHz module clock and 16-bit register data
`ifndef RFLMAC_REGS_SVH
`define RFLMAC_REGS_SVH
`define RFL_OFS_NET_ID      4'h0
`define RFL_OFS_ADDR_MASK   4'h1
`define RFL_OFS_DEST_ADDR   4'h2
`define RFL_OFS_DELAY_SLOTS 4'h3
`define RFL_OFS_RETRY_LIM   4'h4
`define RFL_OFS_SYNC_TIME   4'h5
`define RFL_OFS_STREAM_LIM  4'h6
`define RFL_OFS_STATUS      4'h7
`define RFL_RST_NET_ID      16'hFFFF
`define RFL_NET_ID_FACTORY  16'hFFFF
`define RFL_RST_ADDR_MASK   16'hFFFF
`define RFL_RST_DEST_ADDR   16'h0000
`define RFL_RST_DELAY_SLOTS 8'h00
`define RFL_RST_RETRY_LIM   8'h00
`define RFL_RST_SYNC_TIME   8'h00
`define RFL_RST_STREAM_LIM  16'hFFFF
`define RFL_RST_LFSR        16'hACE1
`define RFL_ST_SYNC_LIVE    0
`define RFL_ST_WAIT_ACK     1
`define RFL_ST_BACKOFF      2
`define RFL_ST_PAUSE        3
`define RFL_ST_ATTEMPT_LSB  8
`define RFL_FIFO_DEPTH      4
`define RFL_CLK_MHZ         100
`define RFL_SLOT_MS         38
`define RFL_SESS_UNIT_MS    100
`define RFL_SLOT_CYC  (`RFL_SLOT_MS * `RFL_CLK_MHZ * 1000)
`define RFL_UNIT_CYC  (`RFL_SESS_UNIT_MS * `RFL_CLK_MHZ * 1000)
`endif

// File: rflmac_pkg.sv
// types shared by the mac and its peer radio model
// assumes nothing beyond a systemverilog compiler
`default_nettype none
package rflmac_pkg;
   typedef struct packed {
      logic [15:0] net_id;
      logic [15:0] dest;
      logic        with_sync;
      logic [7:0]  data;
   } rflmac_air_tx_t;
   typedef struct packed {
      logic [15:0] net_id;
      logic [15:0] dest;
      logic [7:0]  data;
   } rflmac_air_rx_t;
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_SEND,
      ST_WAIT_ACK,
      ST_BACKOFF,
      ST_PAUSE
   } rflmac_state_t;
endpackage : rflmac_pkg
`default_nettype wire

// File: rflmac_radio_model.sv
// peer radio on the air side of the mac: takes packets, returns acks,
// injects received packets; assumes the bench steers ack_on and stall
`default_nettype none
module rflmac_radio_model (
   input  wire logic                       i_clk,
   input  wire logic                       i_rst,
   input  wire rflmac_pkg::rflmac_air_tx_t i_air_tx,
   input  wire logic                       i_air_tx_valid,
   output logic                            o_tx_ready,
   output logic                            o_ack,
   output rflmac_pkg::rflmac_air_rx_t      o_rx,
   output logic                            o_rx_valid
);
   timeunit 1ns;
   timeprecision 1ps;
   bit                         ack_on = 1'b0;
   bit                         stall  = 1'b0;
   int                         cyc    = 0;
   logic [1:0]                 ack_cnt_q;
   rflmac_pkg::rflmac_air_tx_t pkts[$];
   int                         times[$];
   initial
   begin
      o_rx       = '0;
      o_rx_valid = 1'b0;
      o_tx_ready = 1'b0;
      o_ack      = 1'b0;
      ack_cnt_q  = 2'd0;
   end
   // ready one cycle late so the mac must hold its packet
   always @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_tx_ready <= 1'b0;
         o_ack      <= 1'b0;
         ack_cnt_q  <= 2'd0;
      end
      else
      begin
         cyc        <= cyc + 1;
         o_tx_ready <= i_air_tx_valid && !stall && !o_tx_ready;
         o_ack      <= (ack_cnt_q == 2'd1);
         if (ack_cnt_q != 2'd0)
            ack_cnt_q <= ack_cnt_q - 2'd1;
         if (i_air_tx_valid && o_tx_ready)
         begin
            pkts.push_back(i_air_tx);
            times.push_back(cyc);
            if (ack_on)
               ack_cnt_q <= 2'd3;
         end
      end
   end
   task automatic send_rx(input logic [15:0] id, input logic [15:0] dest,
                          input logic [7:0] d);
      @(posedge i_clk);
      o_rx       <= '{net_id: id, dest: dest, data: d};
      o_rx_valid <= 1'b1;
      @(posedge i_clk);
      o_rx_valid <= 1'b0;
      // released bus must not look like a stale packet
      o_rx       <= ~o_rx;
   endtask
endmodule // rflmac_radio_model
`default_nettype wire

// File: tb_top.sv
// self-checking bench of the mac with a peer radio model
// assumes short slot and session counts given as parameters
`include "rflmac_regs.svh"
`default_nettype none
`define CHK(act, exp) \
   begin \
      total_checks++; \
      if ((act) !== (exp)) \
      begin \
         n_fail++; \
         $display("mismatch at %0t: got %0h exp %0h", $time, act, exp); \
      end \
   end
`define RM i_rflmac_radio_model
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [15:0] FAC_ID = 16'h3C3C; // arbitrary value
   logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
   logic [3:0]  addr = 4'h0;
   logic [15:0] wdata = 16'h0000, rdata;
   logic        tx_valid = 1'b0, tx_ready, air_tx_valid, air_tx_ready;
   logic [7:0]  tx_data = 8'h00, rx_data;
   logic        air_ack, air_rx_valid, ack_send, rx_valid, sync_live;
   rflmac_pkg::rflmac_air_tx_t air_tx;
   rflmac_pkg::rflmac_air_rx_t air_rx;
   int n_fail = 0, total_checks = 0;
   always #5 clk = ~clk;
   rflmac_top #(.SLOT_CYC(20), .UNIT_CYC(50), .FACTORY_ID(FAC_ID))
   i_rflmac_top (.i_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_tx_valid(tx_valid),
      .i_tx_data(tx_data), .o_tx_ready(tx_ready), .o_air_tx(air_tx),
      .o_air_tx_valid(air_tx_valid), .i_air_tx_ready(air_tx_ready),
      .i_air_ack(air_ack), .i_air_rx(air_rx),
      .i_air_rx_valid(air_rx_valid), .o_ack_send(ack_send),
      .o_rx_valid(rx_valid), .o_rx_data(rx_data), .o_sync_live(sync_live));
   rflmac_radio_model i_rflmac_radio_model (.i_clk(clk), .i_rst(rst),
      .i_air_tx(air_tx), .i_air_tx_valid(air_tx_valid),
      .o_tx_ready(air_tx_ready), .o_ack(air_ack), .o_rx(air_rx),
      .o_rx_valid(air_rx_valid));
   task automatic end_sim;
      if (n_fail == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      `CHK(rdata, e)
   endtask
   // ready is combinational from the fifo, so look at it between edges
   task automatic push(input logic [7:0] b);
      @(posedge clk);
      tx_valid <= 1'b1;
      tx_data <= b;
      for (int k = 0; k < 500; k++)
      begin
         @(negedge clk);
         if (tx_ready)
            break;
      end
      if (!tx_ready)
      begin
         n_fail++;
         $display("mismatch at %0t: push timeout", $time);
         end_sim();
      end
      @(posedge clk);
      tx_valid <= 1'b0;
   endtask
   task automatic wait_pkts(input int n);
      for (int k = 0; k < 2000 && `RM.pkts.size() < n; k++)
      begin
         @(posedge clk);
         #1;
      end
      if (`RM.pkts.size() < n)
      begin
         n_fail++;
         $display("mismatch at %0t: packet timeout", $time);
         end_sim();
      end
   endtask
   task automatic fill_stalled;
      int cnt;
      cnt = 0;
      `RM.stall = 1'b1;
      @(posedge clk);
      tx_valid <= 1'b1;
      tx_data <= 8'h40;
      for (int k = 0; k < 8; k++)
      begin
         @(negedge clk);
         if (!tx_ready)
            break;
         @(posedge clk);
         tx_data <= tx_data + 8'h01;
         cnt++;
      end
      `CHK(cnt, 4)
      @(posedge clk);
      tx_valid <= 1'b0;
      `RM.stall = 1'b0;
   endtask
   task automatic t_regs;
      rd_chk(`RFL_OFS_NET_ID, 16'hFFFF);
      rd_chk(`RFL_OFS_ADDR_MASK, 16'hFFFF);
      rd_chk(`RFL_OFS_DEST_ADDR, 16'h0000);
      rd_chk(`RFL_OFS_DELAY_SLOTS, 16'h0000);
      rd_chk(`RFL_OFS_RETRY_LIM, 16'h0000);
      rd_chk(`RFL_OFS_SYNC_TIME, 16'h0000);
      rd_chk(`RFL_OFS_STREAM_LIM, 16'hFFFF);
      wr_reg(`RFL_OFS_DELAY_SLOTS, 16'h1234);
      rd_chk(`RFL_OFS_DELAY_SLOTS, 16'h0034);
      wr_reg(4'h8, 16'hBEEF);
      rd_chk(4'h8, 16'h0000);
   endtask
   task automatic t_tx_basic;
      int b;
      b = `RM.pkts.size();
      wr_reg(`RFL_OFS_DELAY_SLOTS, 16'h0000);
      wr_reg(`RFL_OFS_DEST_ADDR, 16'h1234);
      push(8'h11);
      push(8'h22);
      push(8'h33);
      wait_pkts(b + 3);
      repeat (60) @(posedge clk);
      `CHK(`RM.pkts.size(), b + 3)
      for (int i = 0; i < 3; i++)
      begin
         `CHK(`RM.pkts[b+i].net_id, FAC_ID)
         `CHK(`RM.pkts[b+i].dest, 16'h1234)
         `CHK(`RM.pkts[b+i].with_sync, 1'b1)
         `CHK(`RM.pkts[b+i].data, 8'(8'h11 * (i + 1)))
      end
      `CHK(sync_live, 1'b0)
   endtask
   task automatic t_retry;
      int b;
      wr_reg(`RFL_OFS_RETRY_LIM, 16'h0003);
      b = `RM.pkts.size();
      push(8'h55);
      repeat (150) @(posedge clk);
      `CHK(`RM.pkts.size(), b + 3)
      for (int i = 0; i < 3; i++)
         `CHK(`RM.pkts[b+i].data, 8'h55)
      `CHK((`RM.times[b+1] - `RM.times[b]) inside {[20:30]}, 1'b1)
      `RM.ack_on = 1'b1;
      b = `RM.pkts.size();
      push(8'h66);
      repeat (100) @(posedge clk);
      `CHK(`RM.pkts.size(), b + 1)
      `RM.ack_on = 1'b0;
   endtask
   task automatic t_backoff;
      int b;
      wr_reg(`RFL_OFS_DELAY_SLOTS, 16'h0004);
      wr_reg(`RFL_OFS_RETRY_LIM, 16'h0002);
      for (int i = 0; i < 3; i++)
      begin
         b = `RM.pkts.size();
         push(8'h70 + 8'(i));
         wait_pkts(b + 2);
         repeat (130) @(posedge clk);
         `CHK((`RM.times[b+1] - `RM.times[b]) inside {[20:90]}, 1'b1)
         `CHK(`RM.pkts.size(), b + 2)
      end
   endtask
   task automatic t_stream;
      int b;
      wr_reg(`RFL_OFS_RETRY_LIM, 16'h0000);
      wr_reg(`RFL_OFS_DELAY_SLOTS, 16'h0001);
      wr_reg(`RFL_OFS_STREAM_LIM, 16'h0002);
      b = `RM.pkts.size();
      fill_stalled();
      wait_pkts(b + 4);
      for (int i = 0; i < 4; i++)
         `CHK(`RM.pkts[b+i].data, 8'h40 + 8'(i))
      `CHK((`RM.times[b+1] - `RM.times[b]) < 20, 1'b1)
      `CHK((`RM.times[b+2] - `RM.times[b+1]) inside {[20:50]}, 1'b1)
      wr_reg(`RFL_OFS_STREAM_LIM, 16'h0000);
      repeat (60) @(posedge clk);
      b = `RM.pkts.size();
      fill_stalled();
      wait_pkts(b + 4);
      for (int i = 1; i < 4; i++)
         `CHK((`RM.times[b+i] - `RM.times[b+i-1]) < 20, 1'b1)
   endtask
   task automatic t_sync;
      int b;
      wr_reg(`RFL_OFS_SYNC_TIME, 16'h0002);
      b = `RM.pkts.size();
      push(8'h77);
      wait_pkts(b + 1);
      push(8'h78);
      wait_pkts(b + 2);
      `CHK(`RM.pkts[b].with_sync, 1'b1)
      `CHK(`RM.pkts[b+1].with_sync, 1'b0)
      `CHK(sync_live, 1'b1)
      rd_chk(`RFL_OFS_STATUS, 16'h0101);
      repeat (170) @(posedge clk);
      `CHK(sync_live, 1'b0)
      push(8'h79);
      wait_pkts(b + 3);
      `CHK(`RM.pkts[b+2].with_sync, 1'b1)
      wr_reg(`RFL_OFS_SYNC_TIME, 16'h0000);
   endtask
   task automatic rx_case(input logic [15:0] id, input logic [15:0] dest,
                          input logic e);
      `RM.send_rx(id, dest, dest[7:0] ^ 8'hA5);
      #1;
      `CHK(rx_valid, e)
      `CHK(ack_send, e)
      if (e)
         `CHK(rx_data, dest[7:0] ^ 8'hA5)
   endtask
   task automatic t_rx;
      int b;
      wr_reg(`RFL_OFS_RETRY_LIM, 16'h0001);
      wr_reg(`RFL_OFS_DEST_ADDR, 16'h0034);
      wr_reg(`RFL_OFS_ADDR_MASK, 16'h00FF);
      rx_case(FAC_ID, 16'hAB34, 1'b1);
      rx_case(FAC_ID, 16'h12FF, 1'b1);
      rx_case(FAC_ID, 16'h1235, 1'b0);
      rx_case(16'h1111, 16'h0034, 1'b0);
      wr_reg(`RFL_OFS_ADDR_MASK, 16'h0000);
      rx_case(FAC_ID, 16'h9999, 1'b1);
      wr_reg(`RFL_OFS_ADDR_MASK, 16'hFFFF);
      rx_case(FAC_ID, 16'h0034, 1'b1);
      rx_case(FAC_ID, 16'h0035, 1'b0);
      wr_reg(`RFL_OFS_NET_ID, 16'h1111);
      rx_case(16'h1111, 16'h0034, 1'b1);
      rx_case(FAC_ID, 16'h0034, 1'b0);
      `RM.ack_on = 1'b1;
      b = `RM.pkts.size();
      push(8'h99);
      wait_pkts(b + 1);
      `CHK(`RM.pkts[b].net_id, 16'h1111)
   endtask
   initial
   begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_tx_basic();
      t_retry();
      t_backoff();
      t_stream();
      t_sync();
      t_rx();
      repeat (20) @(posedge clk);
      end_sim();
   end
endmodule // tb_top
`default_nettype wire
